// ==== event_flag_cell.sv ====
/*
 * One event flag with selectable stickiness. A sticky flag holds until a
 * one is written to it; a normal flag clears at each packet start or
 * follows its level input when FOLLOW is set.
 * Assumes event_in and pkt_start are synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module event_flag_cell #(
    parameter bit FOLLOW = 1'b0
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic sticky,
    input  wire logic event_in,
    input  wire logic pkt_start,
    input  wire logic clear_wr,
    output var  logic flag
);

    logic next_flag;

    // Computes the next flag value; a new event always beats a clear.
    always_comb begin
        next_flag = flag;
        if (sticky) begin
            if (clear_wr) begin
                next_flag = 1'b0;
            end
            if (event_in) begin
                next_flag = 1'b1;
            end
        end else if (FOLLOW) begin
            next_flag = event_in;
        end else begin
            if (pkt_start || clear_wr) begin
                next_flag = 1'b0;
            end
            if (event_in) begin
                next_flag = 1'b1;
            end
        end
    end

    // Registers the flag.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

endmodule : event_flag_cell

`default_nettype wire

// ==== tb_usb_phy_status_flags.sv ====
/*
 * Self-checking bench of the status, serial and event flag registers.
 * Assumes the design package and the transceiver model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_usb_phy_status_flags
    import usb_phy_status_pkg::*;
;

    logic              sys_clk = 1'b0;
    logic              rst = 1'b1;
    logic              reg_wr_en = 1'b0;
    logic              reg_rd_en = 1'b0;
    logic [7:0]        reg_addr = 8'h00;
    logic [31:0]       reg_wdata = 32'h0;
    logic [31:0]       reg_rdata;
    logic              reg_rd_valid;
    logic [5:0]        otg_in = 6'h00;
    logic              rx_rcv, rx_dm, rx_dp;
    logic              tx_se0, tx_data, tx_enable_n, fsls_serial;
    logic [1:0]        line_state;
    logic [1:0]        far_level = 2'b11;
    logic              packet_start = 1'b0;
    logic              token_valid = 1'b0;
    logic [ADDR_W-1:0] token_addr = 7'h00;
    logic              token_crc5_ok = 1'b0;
    logic              token_pid_ok = 1'b0;
    logic              crc16_fail = 1'b0;
    logic              rx_active = 1'b0;
    logic              rx_error = 1'b0;
    logic [ADDR_W-1:0] dev_addr;
    logic              s0, d0;
    logic [31:0]       exp_q[$];
    int                error_cnt = 0;
    int                comparisons = 0;

    always #2.5 sys_clk = ~sys_clk;

    usb_phy_status_flags i_usb_phy_status_flags (
        .sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .bvalid(otg_in[5]), .id_gnd(otg_in[4]),
        .host_disconnect(otg_in[3]), .vbus_valid(otg_in[2]),
        .session_valid(otg_in[1]), .session_end(otg_in[0]),
        .rx_rcv(rx_rcv), .rx_dm(rx_dm), .rx_dp(rx_dp), .tx_se0(tx_se0),
        .tx_data(tx_data), .tx_enable_n(tx_enable_n),
        .fsls_serial(fsls_serial), .line_state(line_state),
        .packet_start(packet_start), .token_valid(token_valid),
        .token_addr(token_addr), .token_crc5_ok(token_crc5_ok),
        .token_pid_ok(token_pid_ok), .crc16_fail(crc16_fail),
        .rx_active(rx_active), .rx_error(rx_error)
    );

    utmi_side_model i_utmi_side_model (
        .sys_clk(sys_clk), .tx_se0(tx_se0), .tx_data(tx_data),
        .tx_enable_n(tx_enable_n), .far_level(far_level),
        .rx_rcv(rx_rcv), .rx_dm(rx_dm), .rx_dp(rx_dp),
        .line_state(line_state)
    );

    ////////////////////////////////////////////////////////////////////////
    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // One register write; the strobe lasts a single cycle.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask : wr

    // One register read; the expected word waits in the queue.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        exp_q.push_back(e);
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        @(posedge sys_clk);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    // Drives {rx_active, rx_error, crc16_fail} from the next edge on.
    task automatic ev(input logic [2:0] v);
        @(posedge sys_clk);
        {rx_active, rx_error, crc16_fail} <= v;
    endtask : ev

    task automatic pstart();
        @(posedge sys_clk);
        packet_start <= 1'b1;
        @(posedge sys_clk);
        packet_start <= 1'b0;
        idle(2);
    endtask : pstart

    ////////////////////////////////////////////////////////////////////////
    // Each read answer is matched with the oldest expected word.
    always @(posedge sys_clk) begin
        if (reg_rd_valid === 1'b1) begin
            check(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
        end
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        $display("timeout at %0t", $time);
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        void'($urandom(70549));
        idle(20);
        rst <= 1'b0;
        idle(2);
        check({28'h0, tx_se0, tx_data, tx_enable_n, fsls_serial},
              32'h2);
        rd(OFS_OTG_STATUS, 32'h0);
        rd(OFS_SERIAL_CTRL, 32'h72);
        rd(OFS_EVENT_FLAGS, 32'h0);
        rd(OFS_STICKY_MASK, 32'h0);
        rd(OFS_DEVICE_ADDRESS, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            otg_in <= 6'($urandom_range(63, 0));
            wr(OFS_OTG_STATUS, 32'hffff_ffff);
            idle(2);
            rd(OFS_OTG_STATUS, {26'h0, otg_in});
        end
        $display("test on-the-go status done");
        for (int k = 0; k < 4; k++) begin
            s0 = k[1];
            d0 = k[0];
            wr(OFS_SERIAL_CTRL, {28'hfff_ffff, s0, d0, 2'b01});
            idle(3);
            check({28'h0, tx_se0, tx_data, tx_enable_n, fsls_serial},
                  {28'h0, s0, d0, 2'b01});
            rd(OFS_SERIAL_CTRL, {25'h0, d0 & ~s0, ~d0 & ~s0, d0 & ~s0,
                                 s0, d0, 2'b01});
        end
        wr(OFS_SERIAL_CTRL, 32'h2);
        idle(3);
        pstart();
        rd(OFS_EVENT_FLAGS, 32'h0);
        $display("test serial line done");
        far_level <= 2'b10;
        idle(3);
        rd(OFS_EVENT_FLAGS, 32'h10);
        far_level <= 2'b01;
        idle(3);
        rd(OFS_EVENT_FLAGS, 32'h18);
        pstart();
        rd(OFS_EVENT_FLAGS, 32'h08);
        far_level <= 2'b00;
        idle(3);
        rd(OFS_EVENT_FLAGS, 32'h28);
        far_level <= 2'b11;
        idle(2);
        pstart();
        rd(OFS_EVENT_FLAGS, 32'h0);
        $display("test line flags done");
        wr(OFS_STICKY_MASK, 32'hffff_ffff);
        rd(OFS_STICKY_MASK, 32'h7f);
        // A short J on the line must stay caught in the sticky J flag.
        far_level <= 2'b01;
        ev(3'b111);
        ev(3'b000);
        far_level <= 2'b11;
        idle(3);
        rd(OFS_EVENT_FLAGS, 32'h0f);
        pstart();
        wr(OFS_EVENT_FLAGS, 32'h0);
        rd(OFS_EVENT_FLAGS, 32'h0f);
        wr(OFS_EVENT_FLAGS, 32'h5);
        rd(OFS_EVENT_FLAGS, 32'h0a);
        wr(OFS_EVENT_FLAGS, 32'ha);
        rd(OFS_EVENT_FLAGS, 32'h0);
        wr(OFS_STICKY_MASK, 32'h0);
        ev(3'b100);
        idle(3);
        rd(OFS_EVENT_FLAGS, 32'h02);
        ev(3'b010);
        idle(3);
        rd(OFS_EVENT_FLAGS, 32'h01);
        ev(3'b001);
        ev(3'b000);
        idle(3);
        rd(OFS_EVENT_FLAGS, 32'h04);
        pstart();
        rd(OFS_EVENT_FLAGS, 32'h0);
        $display("test stickiness done");
        dev_addr = 7'($urandom_range(127, 0));
        wr(OFS_DEVICE_ADDRESS, {25'h1ff_ffff, dev_addr});
        rd(OFS_DEVICE_ADDRESS, {25'h0, dev_addr});
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            token_valid   <= 1'b1;
            token_addr    <= (i == 1) ? dev_addr ^ 7'h01 : dev_addr;
            token_crc5_ok <= (i != 2);
            token_pid_ok  <= (i != 3);
            @(posedge sys_clk);
            token_valid <= 1'b0;
            idle(3);
            rd(OFS_EVENT_FLAGS, (i == 0) ? 32'h40 : 32'h0);
            pstart();
        end
        $display("test token match done");
        rd(8'h24, 32'h0);
        wr(OFS_SERIAL_CTRL, 32'h0);
        wr(OFS_SOFT_RESET, 32'h0);
        idle(2);
        check({31'h0, tx_enable_n}, 32'h1);
        rd(OFS_DEVICE_ADDRESS, 32'h0);
        $display("test soft reset done");
        for (int w = 0; w < 20 && exp_q.size() > 0; w++) begin
            @(posedge sys_clk);
        end
        if (exp_q.size() > 0) begin
            error_cnt++;
        end
        end_of_test();
    end

endmodule : tb_usb_phy_status_flags

`default_nettype wire

// ==== token_match.sv ====
/*
 * Token qualifier: a decoded token counts only when its CRC5 and PID
 * checks pass and its address equals the programmed device address.
 * Assumes the decoder gives one strobe per token with its checks valid.
 */
`timescale 1ns/1ps
`default_nettype none

module token_match
    import usb_phy_status_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              token_valid,
    input  wire logic [ADDR_W-1:0] token_addr,
    input  wire logic              token_crc5_ok,
    input  wire logic              token_pid_ok,
    input  wire logic [ADDR_W-1:0] device_address,
    output var  logic              token_hit
);

    logic next_token_hit;

    // A token passes only with both checks good and the address equal.
    always_comb begin
        next_token_hit = token_valid && token_crc5_ok && token_pid_ok
                         && (token_addr == device_address);
    end

    // Registers the one-cycle hit pulse.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            token_hit <= 1'b0;
        end else begin
            token_hit <= next_token_hit;
        end
    end

endmodule : token_match

`default_nettype wire

// ==== usb_phy_status_flags.sv ====
/*
 * Status, serial line control and event flag registers of the USB
 * interface machine, reached by 32-bit peripheral reads and writes.
 * Assumes all transceiver and decoder inputs are synchronous to sys_clk
 * and that a read or write strobe lasts one cycle.
 */
//
// Contract
// - OTG status bits 5..0 copy Bvalid, IDGND, HOSTDIS, VBUSVLD, SESSVLD, SESSEND.
// - Serial control bits 6, 5, 4 read differential, D-minus, D-plus receivers.
// - Serial bits 3, 2, 0 drive SE0 request, transmit data, speed select.
// - Serial bit 1 resets to one; it is the active-low transmit enable.
// - Flag 6 sets on a token with good CRC5, PID and matching address.
// - Flags 5, 4, 3 set on line state SE0, K and J.
// - Flag 2 sets when a data packet fails its CRC16 check.
// - Flag 1 follows receive-active, flag 0 follows receive-error.
// - Normal flags 6..2 clear at the next packet start; flags 1 and 0 follow later changes.
// - A stickiness mask one holds its flag until software writes one.
// - Tokens match a 7-bit device address register resetting to zero.
`timescale 1ns/1ps
`default_nettype none

module usb_phy_status_flags
    import usb_phy_status_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    output var  logic [31:0]       reg_rdata,
    output var  logic              reg_rd_valid,
    input  wire logic              bvalid,
    input  wire logic              id_gnd,
    input  wire logic              host_disconnect,
    input  wire logic              vbus_valid,
    input  wire logic              session_valid,
    input  wire logic              session_end,
    input  wire logic              rx_rcv,
    input  wire logic              rx_dm,
    input  wire logic              rx_dp,
    output var  logic              tx_se0,
    output var  logic              tx_data,
    output var  logic              tx_enable_n,
    output var  logic              fsls_serial,
    input  wire logic [1:0]        line_state,
    input  wire logic              packet_start,
    input  wire logic              token_valid,
    input  wire logic [ADDR_W-1:0] token_addr,
    input  wire logic              token_crc5_ok,
    input  wire logic              token_pid_ok,
    input  wire logic              crc16_fail,
    input  wire logic              rx_active,
    input  wire logic              rx_error
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic                soft_rst;
    logic                next_soft_rst;
    logic                state_rst;
    logic [OTG_W-1:0]    otg_status;
    logic [OTG_W-1:0]    next_otg_status;
    logic [2:0]          rx_lines;
    logic [2:0]          next_rx_lines;
    logic [CTRL_W-1:0]   serial_ctrl;
    logic [CTRL_W-1:0]   next_serial_ctrl;
    logic [ADDR_W-1:0]   device_address;
    logic [ADDR_W-1:0]   next_device_address;
    logic [FLAG_W-1:0]   flag_stickiness_select;
    logic [FLAG_W-1:0]   next_flag_stickiness_select;
    logic [FLAG_W-1:0]   event_flags;
    logic [FLAG_W-1:0]   event_in;
    logic [FLAG_W-1:0]   clear_vec;
    logic                token_hit;
    logic [31:0]         next_reg_rdata;
    logic                wr_hit_flags;

    ////////////////////////////////////////////////////////////////////////
    // Interface reset: any write to the reset register clears all state but the read
    // data and valid flops for one cycle; the transmit controls return to their reset values.

    always_comb begin
        next_soft_rst = reg_wr_en && (reg_addr == OFS_SOFT_RESET);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= next_soft_rst;
        end
    end

    assign state_rst = rst || soft_rst;

    ////////////////////////////////////////////////////////////////////////
    // Status copies of the transceiver's session and receiver lines.

    // Samples the inputs every cycle so software reads a settled copy.
    always_comb begin
        next_otg_status = {bvalid, id_gnd, host_disconnect,
                           vbus_valid, session_valid, session_end};
        next_rx_lines   = {rx_rcv, rx_dm, rx_dp};
    end

    always_ff @(posedge sys_clk) begin
        if (state_rst) begin
            otg_status <= OTG_RESET;
            rx_lines   <= 3'h0;
        end else begin
            otg_status <= next_otg_status;
            rx_lines   <= next_rx_lines;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable registers: serial control, device address, stickiness.

    // Only the documented writable fields take write data.
    always_comb begin
        next_serial_ctrl            = serial_ctrl;
        next_device_address         = device_address;
        next_flag_stickiness_select = flag_stickiness_select;
        if (reg_wr_en) begin
            case (reg_addr)
                OFS_SERIAL_CTRL: begin
                    next_serial_ctrl = reg_wdata[CTRL_W-1:0];
                end
                OFS_DEVICE_ADDRESS: begin
                    next_device_address = reg_wdata[ADDR_W-1:0];
                end
                OFS_STICKY_MASK: begin
                    next_flag_stickiness_select = reg_wdata[FLAG_W-1:0];
                end
                default: begin
                    next_serial_ctrl = serial_ctrl;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (state_rst) begin
            serial_ctrl            <= SERIAL_CTRL_RESET;
            device_address         <= ADDRESS_RESET;
            flag_stickiness_select <= STICKY_RESET;
        end else begin
            serial_ctrl            <= next_serial_ctrl;
            device_address         <= next_device_address;
            flag_stickiness_select <= next_flag_stickiness_select;
        end
    end

    // Transmit controls come straight from the register flops.
    assign tx_se0      = serial_ctrl[BIT_TX_SE0];
    assign tx_data     = serial_ctrl[BIT_TX_DATA];
    assign tx_enable_n = serial_ctrl[BIT_TX_ENABLE_N];
    assign fsls_serial = serial_ctrl[BIT_FSLS];

    ////////////////////////////////////////////////////////////////////////
    // Event sources and flags.

    token_match u_token_match (
        .sys_clk        (sys_clk),
        .rst            (state_rst),
        .token_valid    (token_valid),
        .token_addr     (token_addr),
        .token_crc5_ok  (token_crc5_ok),
        .token_pid_ok   (token_pid_ok),
        .device_address (device_address),
        .token_hit      (token_hit)
    );

    // Maps each monitored condition onto its flag position.
    always_comb begin
        event_in                = '0;
        event_in[BIT_TOKEN_OK]  = token_hit;
        event_in[BIT_SE0]       = (line_state == LS_SE0);
        event_in[BIT_K]         = (line_state == LS_K);
        event_in[BIT_J]         = (line_state == LS_J);
        event_in[BIT_CRC16_BAD] = crc16_fail;
        event_in[BIT_RX_ACTIVE] = rx_active;
        event_in[BIT_RX_ERROR]  = rx_error;
    end

    // Write-one-to-clear; a zero bit leaves its flag alone.
    assign wr_hit_flags = reg_wr_en && (reg_addr == OFS_EVENT_FLAGS);
    assign clear_vec    = wr_hit_flags ? reg_wdata[FLAG_W-1:0] : '0;

    // One cell per flag; the stickiness bit picks its behaviour.
    for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
        event_flag_cell #(
            .FOLLOW (FOLLOW_MASK[i])
        ) u_cell (
            .sys_clk   (sys_clk),
            .rst       (state_rst),
            .sticky    (flag_stickiness_select[i]),
            .event_in  (event_in[i]),
            .pkt_start (packet_start),
            .clear_wr  (clear_vec[i]),
            .flag      (event_flags[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: data one cycle after the strobe, unmapped reads zero.

    always_comb begin
        next_reg_rdata = 32'h0000_0000;
        if (reg_rd_en) begin
            case (reg_addr)
                OFS_DEVICE_ADDRESS: begin
                    next_reg_rdata[ADDR_W-1:0] = device_address;
                end
                OFS_OTG_STATUS: begin
                    next_reg_rdata[OTG_W-1:0] = otg_status;
                end
                OFS_SERIAL_CTRL: begin
                    next_reg_rdata[SER_W-1:0] = {rx_lines,
                                                 serial_ctrl};
                end
                OFS_EVENT_FLAGS: begin
                    next_reg_rdata[FLAG_W-1:0] = event_flags;
                end
                OFS_STICKY_MASK: begin
                    next_reg_rdata[FLAG_W-1:0] = flag_stickiness_select;
                end
                default: begin
                    next_reg_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata    <= 32'h0000_0000;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rdata    <= next_reg_rdata;
            reg_rd_valid <= reg_rd_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (state_rst);

    property p_otg_copy;
        !state_rst |=> otg_status == $past({bvalid, id_gnd, host_disconnect,
                                 vbus_valid, session_valid, session_end});
    endproperty
    a_otg_copy: assert property (p_otg_copy)
        else $error("otg status does not copy its inputs");

    property p_rx_read;
        reg_rd_en && reg_addr == OFS_SERIAL_CTRL && !$past(state_rst)
        |=> reg_rdata[6:4] == $past({rx_rcv, rx_dm, rx_dp}, 2);
    endproperty
    a_rx_read: assert property (p_rx_read)
        else $error("receiver line bits read wrong");

    property p_serial_wr;
        reg_wr_en && reg_addr == OFS_SERIAL_CTRL
        |=> {tx_se0, tx_data, tx_enable_n, fsls_serial}
            == $past(reg_wdata[3:0]);
    endproperty
    a_serial_wr: assert property (p_serial_wr)
        else $error("serial control write not driven out");

    property p_reset_values;
        $fell(rst) |-> tx_enable_n && !tx_se0 && device_address == 7'h00
                       && event_flags == 7'h00;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("wrong value after reset");

    property p_token_flag;
        !state_rst && token_valid && token_crc5_ok && token_pid_ok
        && token_addr == device_address && !wr_hit_flags
        ##1 !wr_hit_flags |=> event_flags[BIT_TOKEN_OK];
    endproperty
    a_token_flag: assert property (p_token_flag)
        else $error("matching token did not set its flag");

    property p_line_k;
        !state_rst && line_state == LS_K |=> event_flags[BIT_K];
    endproperty
    a_line_k: assert property (p_line_k)
        else $error("K line state did not set its flag");

    property p_crc16;
        !state_rst && crc16_fail |=> event_flags[BIT_CRC16_BAD];
    endproperty
    a_crc16: assert property (p_crc16)
        else $error("CRC16 failure did not set its flag");

    property p_follow;
        !state_rst && !flag_stickiness_select[BIT_RX_ACTIVE]
        |=> event_flags[BIT_RX_ACTIVE] == $past(rx_active);
    endproperty
    a_follow: assert property (p_follow)
        else $error("receive-active flag does not follow");

    property p_pkt_clear;
        packet_start && !flag_stickiness_select[BIT_CRC16_BAD]
        && !crc16_fail |=> !event_flags[BIT_CRC16_BAD];
    endproperty
    a_pkt_clear: assert property (p_pkt_clear)
        else $error("normal flag not cleared at packet start");

    property p_sticky_hold;
        !state_rst && flag_stickiness_select[BIT_J] && event_flags[BIT_J]
        && !clear_vec[BIT_J] |=> event_flags[BIT_J];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("sticky flag lost without a clear");

    property p_addr_write;
        reg_wr_en && reg_addr == OFS_DEVICE_ADDRESS
        |=> device_address == $past(reg_wdata[6:0]);
    endproperty
    a_addr_write: assert property (p_addr_write)
        else $error("device address not stored");

    property p_reserved_zero;
        reg_rd_en && reg_addr == OFS_EVENT_FLAGS |=> reg_rdata[31:7] == 0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved flag bits read nonzero");

    c_token: cover property (token_hit ##1 event_flags[BIT_TOKEN_OK]);
    c_sticky_clear: cover property (
        flag_stickiness_select[BIT_SE0] && clear_vec[BIT_SE0]
        ##1 !event_flags[BIT_SE0]);
    c_soft_reset: cover property (reg_wr_en && reg_addr == OFS_SOFT_RESET);

endmodule : usb_phy_status_flags

`default_nettype wire

// ==== usb_phy_status_pkg.sv ====
/*
 * Shared constants of the status, serial line control and event flag
 * registers of the USB interface machine: offsets, field positions,
 * widths, reset values and the decoded line state codes.
 * Assumes nothing of its surroundings; usb_phy_status_flags, token_match and the bench import it.
 */
package usb_phy_status_pkg;

    // Register byte offsets on the 32-bit peripheral access path.
    localparam logic [7:0] OFS_SOFT_RESET     = 8'h00;
    localparam logic [7:0] OFS_DEVICE_ADDRESS = 8'h08;
    localparam logic [7:0] OFS_OTG_STATUS     = 8'h14;
    localparam logic [7:0] OFS_SERIAL_CTRL    = 8'h18;
    localparam logic [7:0] OFS_EVENT_FLAGS    = 8'h1c;
    localparam logic [7:0] OFS_STICKY_MASK    = 8'h20;

    // Field widths.
    localparam int OTG_W   = 6;
    localparam int SER_W   = 7;
    localparam int CTRL_W  = 4;
    localparam int FLAG_W  = 7;
    localparam int ADDR_W  = 7;

    // Serial line control field positions.
    localparam int BIT_RX_RCV      = 6;
    localparam int BIT_RX_DM       = 5;
    localparam int BIT_RX_DP       = 4;
    localparam int BIT_TX_SE0      = 3;
    localparam int BIT_TX_DATA     = 2;
    localparam int BIT_TX_ENABLE_N = 1;
    localparam int BIT_FSLS        = 0;

    // Event flag field positions.
    localparam int BIT_TOKEN_OK  = 6;
    localparam int BIT_SE0       = 5;
    localparam int BIT_K         = 4;
    localparam int BIT_J         = 3;
    localparam int BIT_CRC16_BAD = 2;
    localparam int BIT_RX_ACTIVE = 1;
    localparam int BIT_RX_ERROR  = 0;

    // Reset values.
    localparam logic [CTRL_W-1:0] SERIAL_CTRL_RESET = 4'h2;
    localparam logic [FLAG_W-1:0] FLAGS_RESET       = 7'h00;
    localparam logic [FLAG_W-1:0] STICKY_RESET      = 7'h00;
    localparam logic [ADDR_W-1:0] ADDRESS_RESET     = 7'h00;
    localparam logic [OTG_W-1:0]  OTG_RESET         = 6'h00;

    // Flags that follow a level instead of catching an event.
    localparam logic [FLAG_W-1:0] FOLLOW_MASK = 7'h03;

    // Decoded full-speed line state.
    typedef enum logic [1:0] {
        LS_SE0 = 2'b00,
        LS_J   = 2'b01,
        LS_K   = 2'b10,
        LS_SE1 = 2'b11
    } line_state_t;

endpackage : usb_phy_status_pkg

// ==== utmi_side_model.sv ====
/*
 * Behavioural transceiver at the far side of the serial line control.
 * Assumes one sys_clk domain; far_level is the bus level {dm, dp} that
 * the remote end drives while our own transmitter is off.
 */
`timescale 1ns/1ps
`default_nettype none

module utmi_side_model (
    input  wire logic       sys_clk,
    input  wire logic       tx_se0,
    input  wire logic       tx_data,
    input  wire logic       tx_enable_n,
    input  wire logic [1:0] far_level,
    output var  logic       rx_rcv,
    output var  logic       rx_dm,
    output var  logic       rx_dp,
    output var  logic [1:0] line_state
);

    logic [1:0] next_lines;

    // Our own enabled transmitter overrides the remote end on the wire.
    always_comb begin
        next_lines = far_level;
        if (tx_enable_n == 1'b0) begin
            next_lines = tx_se0 ? 2'b00 : {~tx_data, tx_data};
        end
    end

    // The receivers report the wire one clock later, as {dm, dp}.
    always_ff @(posedge sys_clk) begin
        rx_dm      <= next_lines[1];
        rx_dp      <= next_lines[0];
        rx_rcv     <= next_lines[0];
        line_state <= next_lines;
    end

endmodule : utmi_side_model

`default_nettype wire
